// file: hw/fws_params.svh
// constants of the flash write-status polling controller: offsets, fields, timing
// assumes a 200 MHz pclk and a 16-bit flash data bus in word mode
//
// What this block does
// - reads paced by output or chip enable
// - host starts with two back-to-back full reads
// - no toggle means done; next read is data
// - toggling plus timing limit: recheck, reset only if still toggling
// - resumed polling restarts from the first read
// - after failure host writes the reset command
// - fast sector commands may skip erase timer
// - host confirms acceptance, checks erase timer bit
// - status reads address the busy bank
// - host presents a valid status address
`ifndef FWS_PARAMS_SVH
`define FWS_PARAMS_SVH

// ******************************************************
// register map (byte offsets on the apb bus)
// ******************************************************
`define FWS_REG_CTRL 12'h000
`define FWS_REG_ADDR 12'h004
`define FWS_REG_WDATA 12'h008
`define FWS_REG_STATUS 12'h00C
`define FWS_REG_RDATA 12'h010

// ctrl fields (write-one pulses and level options)
`define FWS_CTRL_POLL 0
`define FWS_CTRL_WRITE 1
`define FWS_CTRL_READ 2
`define FWS_CTRL_ABORT 3
`define FWS_CTRL_USE_SECTOR 4
`define FWS_CTRL_PACE_CE 5
`define FWS_CTRL_HW_RESET 6

// status fields
`define FWS_ST_BUSY 0
`define FWS_ST_DONE 1
`define FWS_ST_FAIL 2
`define FWS_ST_READY 3
`define FWS_ST_LIMIT 4
`define FWS_ST_ERASE_TIMER 5
`define FWS_ST_SECT_TOG 6
`define FWS_ST_GLOB_TOG 7
`define FWS_ST_POLL_BIT 8

// flash status bit positions on the data bus
`define FWS_DQ_SECTOR_TOGGLE 2
`define FWS_DQ_ERASE_TIMER 3
`define FWS_DQ_TIMING_LIMIT 5
`define FWS_DQ_GLOBAL_TOGGLE 6
`define FWS_DQ_DATA_POLLING 7

// widths and commands
`define FWS_AW 21
`define FWS_DW 16
`define FWS_CMD_RESET 16'h00F0
`define FWS_ZERO32 32'h00000000

// ******************************************************
// timing (ns figures, cycles derived from the clock rate)
// ******************************************************
`define FWS_CLK_MHZ 200
`define FWS_T_ACC_NS 70
`define FWS_T_WP_NS 35
`define FWS_T_REC_NS 20
`define FWS_CYC_UP(ns) (((ns) * `FWS_CLK_MHZ + 999) / 1000)
`define FWS_SYNC_LAT 3
`define FWS_ACC_CYC 8'(`FWS_CYC_UP(`FWS_T_ACC_NS) + `FWS_SYNC_LAT)
`define FWS_WP_CYC 8'(`FWS_CYC_UP(`FWS_T_WP_NS))
`define FWS_REC_CYC 8'(`FWS_CYC_UP(`FWS_T_REC_NS))

`endif

// file: hw/fws_pkg.sv
// types of the flash write-status polling controller
// assumes fws_params.svh is compiled alongside
package fws_pkg;
  // polling sequencer states, gray coded in the order listed
  typedef enum logic [2:0] {
    FWS_IDLE = 3'h0,
    FWS_RD1 = 3'h1,
    FWS_RD2 = 3'h3,
    FWS_CHK = 3'h2,
    FWS_RD3 = 3'h6,
    FWS_RSTC = 3'h7,
    FWS_DATA = 3'h5,
    FWS_ONE = 3'h4
  } fws_state_t;
  // single flash cycle engine states
  typedef enum logic [1:0] {
    FWS_C_IDLE = 2'h0,
    FWS_C_ACT = 2'h1,
    FWS_C_REC = 2'h3
  } fws_cyc_t;
endpackage

// file: hw/fws_sync.sv
// three-stage pin synchroniser, one lane per bit
// assumes inputs are asynchronous to pclk
`timescale 1ns/1ps
module fws_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin side and filtered side
  input wire logic [W-1:0] pin,
  output logic [W-1:0] q
);
  // ******************************************************
  // per-bit lanes
  // ******************************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic s1; // read only by s2
      logic s2;
      logic s3;
      // a change counts only once stages two and three agree
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1 <= INIT[i];
          s2 <= INIT[i];
          s3 <= INIT[i];
          q[i] <= INIT[i];
        end else begin
          s1 <= pin[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            q[i] <= s3;
          end
        end
      end
    end
  endgenerate
endmodule // fws_sync

// file: hw/fws_cycle.sv
// one flash bus cycle (read or write) with strobe pacing
// assumes data pins are already synchronised into dq_sync
`timescale 1ns/1ps
`include "fws_params.svh"
module fws_cycle (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request from the sequencer
  input wire logic start,
  input wire logic is_write,
  input wire logic hold,
  input wire logic pace_ce,
  input wire logic [`FWS_AW-1:0] addr_in,
  input wire logic [`FWS_DW-1:0] wdata_in,
  input wire logic [`FWS_DW-1:0] dq_sync,
  // answer
  output logic done,
  output logic [`FWS_DW-1:0] rdata,
  // flash pins
  output logic [`FWS_AW-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [`FWS_DW-1:0] flash_dq_out,
  output logic flash_dq_oe
);
  import fws_pkg::*;

  fws_cyc_t st; // engine state
  logic [7:0] cnt; // phase countdown
  logic wr; // current cycle is a write

  // ******************************************************
  // cycle engine
  // ******************************************************
  // while polling, the non-pacing strobe stays low so only one strobe edges each read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= FWS_C_IDLE;
      cnt <= 8'h00;
      wr <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      flash_addr <= 21'h000000;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st)
        FWS_C_IDLE: begin
          if (start) begin
            flash_addr <= addr_in;
            wr <= is_write;
            flash_ce_n <= 1'b0;
            if (is_write) begin
              flash_oe_n <= 1'b1;
              flash_we_n <= 1'b0;
              flash_dq_out <= wdata_in;
              flash_dq_oe <= 1'b1;
              cnt <= `FWS_WP_CYC;
            end else begin
              flash_oe_n <= 1'b0;
              cnt <= `FWS_ACC_CYC;
            end
            st <= FWS_C_ACT;
          end else begin
            flash_ce_n <= ~(hold & ~pace_ce);
            flash_oe_n <= ~(hold & pace_ce);
          end
        end
        FWS_C_ACT: begin
          if (cnt == 8'h00) begin
            if (wr) begin
              flash_we_n <= 1'b1; // rising edge latches the word
            end else begin
              rdata <= dq_sync;
              flash_ce_n <= ~(hold & ~pace_ce);
              flash_oe_n <= ~(hold & pace_ce);
            end
            cnt <= `FWS_REC_CYC;
            st <= FWS_C_REC;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        FWS_C_REC: begin
          if (cnt == 8'h00) begin
            flash_dq_oe <= 1'b0;
            flash_ce_n <= ~(hold & ~pace_ce);
            done <= 1'b1;
            st <= FWS_C_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: begin
          st <= FWS_C_IDLE;
        end
      endcase
    end
  end
endmodule // fws_cycle

// file: hw/fws_ctrl.sv
// top of the flash write-status polling controller: apb registers, toggle-bit
// polling sequencer and the flash pin drivers
// assumes one 200 MHz clock; flash pins are asynchronous and pass synchronisers
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "fws_params.svh"
module fws_ctrl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // flash address and strobes
  output logic [`FWS_AW-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_reset_n,
  // flash data bus (two-way, split)
  input wire logic [`FWS_DW-1:0] flash_dq_in,
  output logic [`FWS_DW-1:0] flash_dq_out,
  output logic flash_dq_oe,
  // open-drain ready/busy from the flash
  input wire logic ready_busy_n
);
  import fws_pkg::*;

  // ******************************************************
  // declarations
  // ******************************************************
  fws_state_t state; // polling sequencer state
  logic [`FWS_AW-1:0] addr_reg; // status or target address
  logic [`FWS_DW-1:0] wdata_reg; // word for single writes
  logic use_sector; // compare the sector toggle instead of global
  logic pace_ce; // pace reads with chip enable, else output enable
  logic hw_reset; // software hold on the flash reset pin
  logic abort_req; // stop polling at the next check
  logic done_flag; // last operation finished
  logic fail_flag; // polling ended in a timing-limit failure
  logic limit_seen; // timing limit bit was high in the second read of a pair
  logic [`FWS_DW-1:0] first_word; // earlier read of the pair
  logic [`FWS_DW-1:0] last_word; // latest word read
  logic sect_tog; // sector toggle moved between the pair
  logic glob_tog; // global toggle moved between the pair
  logic cyc_start; // pulse to the cycle engine
  logic cyc_write; // direction for the engine
  logic [`FWS_DW-1:0] cyc_wdata; // data for engine writes
  logic cyc_done; // engine finished a cycle
  logic [`FWS_DW-1:0] cyc_rdata; // word from the engine
  logic [`FWS_DW-1:0] dq_sync; // synchronised data pins
  logic ready_sync; // synchronised ready/busy
  logic polling; // strobe hold while in a polling run
  logic apb_go; // access phase, answered one cycle later
  logic apb_wr; // write lands as pready is sampled high
  logic wr_ctrl; // software write to the control register
  logic toggled; // selected toggle bit moved between two words
  logic cyc_busy; // engine has a cycle in flight

  // ******************************************************
  // synchronisers for the flash pins
  // ******************************************************
  fws_sync #(.W(`FWS_DW), .INIT(16'h0000)) u_dq_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(flash_dq_in),
    .q(dq_sync)
  );

  // ready/busy idles high through its pull-up
  fws_sync #(.W(1), .INIT(1'b1)) u_rb_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ready_busy_n),
    .q(ready_sync)
  );

  // ******************************************************
  // flash cycle engine
  // ******************************************************
  fws_cycle u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .start(cyc_start),
    .is_write(cyc_write),
    .hold(polling),
    .pace_ce(pace_ce),
    .addr_in(addr_reg),
    .wdata_in(cyc_wdata),
    .dq_sync(dq_sync),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe)
  );

  // ******************************************************
  // apb decode
  // ******************************************************
  // answer one cycle into the access phase so prdata can come from a flop
  assign apb_go = psel & penable & ~pready;
  // a write lands only at the edge where the master sees pready, never earlier
  assign apb_wr = psel & penable & pready & pwrite;
  assign wr_ctrl = apb_wr & (paddr == `FWS_REG_CTRL);

  // the toggle test looks at either status bit, chosen by software
  assign toggled = use_sector ?
    (first_word[`FWS_DQ_SECTOR_TOGGLE] != cyc_rdata[`FWS_DQ_SECTOR_TOGGLE]) :
    (first_word[`FWS_DQ_GLOBAL_TOGGLE] != cyc_rdata[`FWS_DQ_GLOBAL_TOGGLE]);

  // strobes stay held only through the status reads of a run
  assign polling = (state == FWS_RD1) | (state == FWS_RD2) | (state == FWS_CHK) |
                   (state == FWS_RD3);

  // ******************************************************
  // apb handshake and read data
  // ******************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= `FWS_ZERO32;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_go;
      pslverr <= 1'b0;
      prdata <= `FWS_ZERO32;
      if (apb_go) begin
        case (paddr)
          `FWS_REG_CTRL: begin
            prdata[`FWS_CTRL_USE_SECTOR] <= use_sector;
            prdata[`FWS_CTRL_PACE_CE] <= pace_ce;
            prdata[`FWS_CTRL_HW_RESET] <= hw_reset;
          end
          `FWS_REG_ADDR: prdata[`FWS_AW-1:0] <= addr_reg;
          `FWS_REG_WDATA: prdata[`FWS_DW-1:0] <= wdata_reg;
          `FWS_REG_STATUS: begin
            prdata[`FWS_ST_BUSY] <= (state != FWS_IDLE);
            prdata[`FWS_ST_DONE] <= done_flag;
            prdata[`FWS_ST_FAIL] <= fail_flag;
            prdata[`FWS_ST_READY] <= ready_sync;
            prdata[`FWS_ST_LIMIT] <= limit_seen;
            prdata[`FWS_ST_ERASE_TIMER] <= last_word[`FWS_DQ_ERASE_TIMER];
            prdata[`FWS_ST_SECT_TOG] <= sect_tog;
            prdata[`FWS_ST_GLOB_TOG] <= glob_tog;
            prdata[`FWS_ST_POLL_BIT] <= last_word[`FWS_DQ_DATA_POLLING];
          end
          `FWS_REG_RDATA: prdata[`FWS_DW-1:0] <= last_word;
          default: begin
            pslverr <= 1'b1; // unmapped offset
          end
        endcase
      end
    end
  end

  // ******************************************************
  // software-written registers
  // ******************************************************
  // address and options are held steady by software across a run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= 21'h000000;
      wdata_reg <= 16'h0000;
      use_sector <= 1'b0;
      pace_ce <= 1'b0;
      hw_reset <= 1'b0;
    end else if (apb_wr) begin
      if (paddr == `FWS_REG_ADDR) begin
        addr_reg <= pwdata[`FWS_AW-1:0];
      end
      if (paddr == `FWS_REG_WDATA) begin
        wdata_reg <= pwdata[`FWS_DW-1:0];
      end
      if (paddr == `FWS_REG_CTRL) begin
        use_sector <= pwdata[`FWS_CTRL_USE_SECTOR];
        pace_ce <= pwdata[`FWS_CTRL_PACE_CE];
        hw_reset <= pwdata[`FWS_CTRL_HW_RESET];
      end
    end
  end

  // ******************************************************
  // flash reset pin
  // ******************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_reset_n <= 1'b1;
    end else begin
      flash_reset_n <= ~hw_reset;
    end
  end

  // ******************************************************
  // abort request
  // ******************************************************
  // a stop taken mid-pair is honoured at the next check; a later start
  // always begins again with a fresh pair, never from stored words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_req <= 1'b0;
    end else if (wr_ctrl & pwdata[`FWS_CTRL_ABORT] & (state != FWS_IDLE)) begin
      abort_req <= 1'b1;
    end else if (state == FWS_IDLE) begin
      abort_req <= 1'b0;
    end
  end

  // ******************************************************
  // polling sequencer
  // ******************************************************
  // runs the toggle-bit walk: a pair of reads, a compare, an optional
  // recheck when the timing limit is up, then a data read or a reset command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= FWS_IDLE;
      cyc_start <= 1'b0;
      cyc_write <= 1'b0;
      cyc_wdata <= 16'h0000;
      cyc_busy <= 1'b0;
    end else begin
      cyc_start <= 1'b0;
      if (cyc_done) begin
        cyc_busy <= 1'b0;
      end
      case (state)
        FWS_IDLE: begin
          if (wr_ctrl & pwdata[`FWS_CTRL_POLL]) begin
            cyc_write <= 1'b0;
            cyc_start <= 1'b1;
            cyc_busy <= 1'b1;
            state <= FWS_RD1;
          end else if (wr_ctrl & pwdata[`FWS_CTRL_WRITE]) begin
            cyc_write <= 1'b1;
            cyc_wdata <= wdata_reg;
            cyc_start <= 1'b1;
            cyc_busy <= 1'b1;
            state <= FWS_ONE;
          end else if (wr_ctrl & pwdata[`FWS_CTRL_READ]) begin
            cyc_write <= 1'b0;
            cyc_start <= 1'b1;
            cyc_busy <= 1'b1;
            state <= FWS_ONE;
          end
        end
        FWS_RD1: begin
          // second read is requested as soon as the first completes, after its recovery
          if (cyc_done) begin
            cyc_start <= 1'b1;
            cyc_busy <= 1'b1;
            state <= FWS_RD2;
          end
        end
        FWS_RD2: begin
          if (cyc_done) begin
            state <= FWS_CHK;
          end
        end
        FWS_CHK: begin
          if (!toggled) begin
            cyc_start <= 1'b1;
            cyc_busy <= 1'b1;
            state <= FWS_DATA;
          end else if (cyc_rdata[`FWS_DQ_TIMING_LIMIT]) begin
            cyc_start <= 1'b1;
            cyc_busy <= 1'b1;
            state <= FWS_RD3;
          end else if (abort_req) begin
            state <= FWS_IDLE;
          end else begin
            cyc_start <= 1'b1; // keep monitoring with a fresh pair
            cyc_busy <= 1'b1;
            state <= FWS_RD1;
          end
        end
        FWS_RD3: begin
          if (cyc_done & toggled) begin
            cyc_write <= 1'b1;
            cyc_wdata <= `FWS_CMD_RESET;
            cyc_start <= 1'b1;
            cyc_busy <= 1'b1;
            state <= FWS_RSTC;
          end else if (cyc_done) begin
            cyc_start <= 1'b1; // stopped as the limit rose: success
            cyc_busy <= 1'b1;
            state <= FWS_DATA;
          end
        end
        FWS_RSTC: begin
          if (cyc_done) begin
            cyc_write <= 1'b0;
            state <= FWS_IDLE;
          end
        end
        FWS_DATA: begin
          if (cyc_done) begin
            state <= FWS_IDLE;
          end
        end
        FWS_ONE: begin
          if (cyc_done) begin
            cyc_write <= 1'b0;
            state <= FWS_IDLE;
          end
        end
        default: begin
          state <= FWS_IDLE;
        end
      endcase
    end
  end

  // ******************************************************
  // captured words and toggle observations
  // ******************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_word <= 16'h0000;
      last_word <= 16'h0000;
      sect_tog <= 1'b0;
      glob_tog <= 1'b0;
    end else begin
      // the recheck read is compared with the pair's second word, not the first
      if (state == FWS_CHK) begin
        first_word <= cyc_rdata;
      end
      if (cyc_done & ~cyc_write) begin
        last_word <= cyc_rdata;
        if (state == FWS_RD1) begin
          first_word <= cyc_rdata;
        end
        if (state == FWS_RD2) begin
          sect_tog <= first_word[`FWS_DQ_SECTOR_TOGGLE] != cyc_rdata[`FWS_DQ_SECTOR_TOGGLE];
          glob_tog <= first_word[`FWS_DQ_GLOBAL_TOGGLE] != cyc_rdata[`FWS_DQ_GLOBAL_TOGGLE];
        end
      end
    end
  end

  // ******************************************************
  // outcome flags
  // ******************************************************
  // cleared by the start of the next run, so a set and a clear never meet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag <= 1'b0;
      fail_flag <= 1'b0;
      limit_seen <= 1'b0;
    end else if ((state == FWS_IDLE) & wr_ctrl & (|pwdata[`FWS_CTRL_READ:`FWS_CTRL_POLL])) begin
      done_flag <= 1'b0;
      fail_flag <= 1'b0;
      limit_seen <= 1'b0;
    end else begin
      if (cyc_done & (state == FWS_RD2) & cyc_rdata[`FWS_DQ_TIMING_LIMIT]) begin
        limit_seen <= 1'b1;
      end
      if (cyc_done & ((state == FWS_DATA) | (state == FWS_ONE) | (state == FWS_RSTC))) begin
        done_flag <= 1'b1;
      end
      if (cyc_done & (state == FWS_RSTC)) begin
        fail_flag <= 1'b1;
      end
      if ((state == FWS_CHK) & toggled & ~cyc_rdata[`FWS_DQ_TIMING_LIMIT] & abort_req) begin
        done_flag <= 1'b1;
      end
    end
  end
endmodule // fws_ctrl

// file: bench/fws_flash_model.sv
// flash model: status bits on the data lines while an operation runs
// assumes the bench arms it by arm() and resolves the shared lines
`timescale 1ns/1ps
module fws_flash_model (
  // strobes
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  // lines driven by the controller
  input wire logic [15:0] din,
  // read data and busy pull-down
  output logic [15:0] dq,
  output logic rb_low
);
  localparam logic [15:0] ARRAY = 16'h4C1A; // stored word, no program sets its zeros
  int left = 0; // busy reads left, endless when inf
  logic er = 1'b0, lim = 1'b0, inf = 1'b0, gt = 1'b0, st = 1'b0, got_rst = 1'b0;
  logic [15:0] last = 16'h0, word;
  wire rd_n = ce_n | oe_n; // either strobe paces a read
  task automatic arm(input int n, input logic e, input logic l, input logic f);
    left = n;
    er = e;
    lim = l;
    inf = f;
    got_rst = 1'b0;
  endtask
  assign rb_low = left > 0;
  // status word while busy, array data once finished
  always_comb word = (left > 0) ? {8'h0, !er & !ARRAY[7], gt, lim, 1'b0, er, er & st, 2'h0}
    : ARRAY;
  // released lines show the inverse of the last word, never a stale copy
  assign dq = rd_n ? ~last : word;
  // every finished read while busy advances the toggles
  always @(posedge rd_n) begin
    last <= word;
    if (left > 0) begin
      gt <= ~gt;
      st <= ~st;
      left <= inf ? left : left - 1;
    end
  end
  // the reset command ends a failed operation
  always @(posedge we_n) begin
    if (!ce_n && din == 16'h00F0) begin
      left <= 0;
      got_rst <= 1'b1;
    end
  end
endmodule // fws_flash_model

// file: bench/fws_ctrl_monitor.sv
// checker of apb and flash strobe timing of the polling controller
// assumes one pclk domain
`timescale 1ns/1ps
`include "fws_params.svh"
module fws_ctrl_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // flash
  input wire logic [`FWS_AW-1:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_dq_oe
);
  wire rd_n = flash_ce_n | flash_oe_n; // read open while both low
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("late pready");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error data not zero");
  a_read_long: assert property ($fell(rd_n) |-> !rd_n [*8])
    else $error("read too short");
  a_read_gap: assert property ($rose(rd_n) |-> rd_n [*3])
    else $error("reads too close");
  a_no_fight: assert property (!rd_n |-> !flash_dq_oe)
    else $error("drive during read");
  a_write_form: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("bad write strobes");
  a_addr_hold: assert property (!rd_n ##1 !rd_n |-> $stable(flash_addr))
    else $error("address moved");
endmodule // fws_ctrl_monitor
bind fws_ctrl fws_ctrl_monitor mon (.pclk, .presetn, .psel, .penable, .pready, .prdata,
  .pslverr, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_oe);

// file: bench/tb_fws_ctrl.sv
// bench of the polling controller: apb tasks, flash model on the pins
// assumes the checker is bound to fws_ctrl
`timescale 1ns/1ps
`include "fws_params.svh"
module tb_fws_ctrl;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n, flash_dq_oe, rb_low;
  logic [`FWS_AW-1:0] flash_addr;
  logic [`FWS_DW-1:0] flash_dq_out, dq_m;
  int fail_count = 0, checks = 0;
  // controller wins the bus while driving; pull-up on ready
  wire [`FWS_DW-1:0] flash_dq_in = flash_dq_oe ? flash_dq_out : dq_m;
  wire ready_busy_n = !rb_low;
  fws_ctrl dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
    .prdata, .pslverr, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n,
    .flash_dq_in, .flash_dq_out, .flash_dq_oe, .ready_busy_n);
  fws_flash_model fl (.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
    .din(flash_dq_out), .dq(dq_m), .rb_low(rb_low));
  initial forever #2.5 pclk = ~pclk;
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; a hang ends the run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      final_report;
    end
  endtask
  // poll status until done, then one fresh status read
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      apb(1'b0, `FWS_REG_STATUS, 32'h0);
      n++;
    end while (q[1] !== 1'b1 && n < 400);
    if (n >= 400) begin
      fail_count++;
      final_report;
    end
    apb(1'b0, `FWS_REG_STATUS, 32'h0);
  endtask
  task automatic run(input int n, input logic e, input logic l, input logic [31:0] c,
    input logic [31:0] st);
    fl.arm(n, e, l, l);
    apb(1'b1, `FWS_REG_ADDR, 32'h123);
    apb(1'b1, `FWS_REG_CTRL, c);
    wait_done;
    chk("status", st, q & 32'h1FF);
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `FWS_REG_STATUS, 32'h0);
    chk("idle status", 32'h8, q);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, {q[30:0], err});
    $display("test idle done");
    fl.arm(1, 1'b0, 1'b0, 1'b1);
    apb(1'b1, `FWS_REG_CTRL, 32'h1);
    repeat (100) @(posedge pclk);
    apb(1'b1, `FWS_REG_CTRL, 32'h8);
    wait_done;
    chk("abort status", 32'h2, q & 32'h1F);
    $display("test abort done");
    run(5, 1'b0, 1'b0, 32'h1, 32'h2A);
    apb(1'b0, `FWS_REG_RDATA, 32'h0);
    chk("program data", 32'h4C1A, q);
    $display("test program done");
    run(4, 1'b1, 1'b0, 32'h31, 32'h2A);
    apb(1'b0, `FWS_REG_RDATA, 32'h0);
    chk("erase data", 32'h4C1A, q);
    $display("test erase done");
    run(1, 1'b0, 1'b1, 32'h1, 32'h19E);
    chk("reset command", 32'h1, {31'h0, fl.got_rst});
    $display("test limit done");
    final_report;
  end
endmodule // tb_fws_ctrl
